// >>> shared/cbm_pkg.sv
// shared constants and types for the local bus cycle master and its system-side partner
`default_nettype none
package cbm_pkg;
  // ****************************************************************
  // widths and timing
  // ****************************************************************
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int CLKS_PER_STATE = 2; // one processor clock = two input clock periods
  localparam int MIN_STATES = 2; // first state plus at least one second state
  localparam int FIFO_DEPTH = 8;

  // ****************************************************************
  // cycle definition codes, ordered {mem_io, data_ctl, wr_rd}
  // ****************************************************************
  localparam logic [2:0] DEF_MEM_RD = 3'h6;
  localparam logic [2:0] DEF_MEM_WR = 3'h7;
  localparam logic [2:0] DEF_IO_RD = 3'h2;
  localparam logic [2:0] DEF_IO_WR = 3'h3;
  localparam logic [2:0] DEF_INT_ACK = 3'h0;
  localparam logic [2:0] DEF_HALT = 3'h5;

  // ****************************************************************
  // pin levels while reset is held
  // ****************************************************************
  localparam logic RST_ADS_N = 1'h1;
  localparam logic [1:0] RST_BEN_N = 2'h0;
  localparam logic [22:0] RST_ADDR_HI = 23'h7fffff;
  localparam logic RST_WR_RD = 1'h0;
  localparam logic RST_DATA_CTL = 1'h1;
  localparam logic RST_MEM_IO = 1'h0;
  localparam logic RST_LOCK_N = 1'h1;
  localparam logic RST_HOLD_ACK = 1'h0;

  // ****************************************************************
  // address spaces
  // ****************************************************************
  localparam logic [23:0] IO_SPACE_TOP = 24'h00ffff;
  localparam logic [23:0] COPRO_FIRST = 24'h8000f8;
  localparam logic [23:0] COPRO_LAST = 24'h8000ff;
  localparam logic [1:0] BEN_LOW_ONLY = 2'h2; // {high_n, low_n}
  localparam logic [1:0] BEN_HIGH_ONLY = 2'h1;
  localparam logic [1:0] BEN_BOTH = 2'h0;

  // ****************************************************************
  // request, cycle descriptor and bus states
  // ****************************************************************
  typedef enum logic [2:0] {
    CBM_MEM_RD, CBM_MEM_RD_LK, CBM_MEM_WR, CBM_MEM_WR_LK,
    CBM_IO_RD, CBM_IO_WR, CBM_INT_ACK, CBM_HALT
  } cbm_kind_t;

  typedef struct packed {
    cbm_kind_t kind;
    logic word;
    logic [23:0] addr;
    logic [15:0] wdata;
  } cbm_req_t;

  typedef struct packed {
    logic [2:0] def;
    logic lock_n;
    logic [22:0] addr_hi;
    logic [1:0] ben_n;
    logic [15:0] wdata;
    logic rd;
    logic wr;
    logic odd;
    logic split_lo;
    logic split_hi;
  } cbm_cyc_t;

  typedef enum logic [2:0] {
    CBM_ST_IDLE, CBM_ST_HOLD, CBM_ST_FIRST, CBM_ST_SECOND, CBM_ST_PIPE_SECOND
  } cbm_state_t;
endpackage
`default_nettype wire

// >>> shared/cbm_bus_if.sv
// local bus pins joining the cycle master and the system logic
`timescale 1ns/1ps
`default_nettype none
interface cbm_bus_if;
  logic [22:0] addr_hi;
  logic high_byte_en_n;
  logic low_byte_en_n;
  logic mem_io;
  logic wr_rd;
  logic data_ctl;
  logic lock_n;
  logic addr_strobe_n;
  logic hold_ack;
  logic [15:0] dev_data;
  logic dev_data_oe;
  logic [15:0] sys_data;
  logic sys_data_oe;
  logic ready_n;
  logic next_addr_req_n;
  logic hold_req;
  logic [15:0] data_bus;

  // wire level of the shared data lines; an undriven bus reads as zero
  assign data_bus = dev_data_oe ? dev_data : (sys_data_oe ? sys_data : 16'h0000);

  modport dev (
    output addr_hi, high_byte_en_n, low_byte_en_n, mem_io, wr_rd, data_ctl, lock_n,
    output addr_strobe_n, hold_ack, dev_data, dev_data_oe,
    input data_bus, ready_n, next_addr_req_n, hold_req
  );
  modport sys (
    input addr_hi, high_byte_en_n, low_byte_en_n, mem_io, wr_rd, data_ctl, lock_n,
    input addr_strobe_n, hold_ack, data_bus,
    output sys_data, sys_data_oe, ready_n, next_addr_req_n, hold_req
  );
endinterface
`default_nettype wire

// >>> logic/cbm_master.sv
// request fifo and the processor-side bus cycle master
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// request fifo
// ****************************************************************
module cbm_req_fifo #(
  parameter int WIDTH = 44,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // fill side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  // drain side
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q, rd_ptr_q;
  logic [AW:0] count_q;
  logic room_q, empty_q;
  logic push, pop;

  if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth must be a power of two");

  assign push = in_valid_in && room_q;
  assign pop = out_ready_in && !empty_q;
  assign in_ready_out = room_q; // straight from a flop, no inverter on the port
  assign out_valid_out = !empty_q;
  assign out_data_out = mem_q[rd_ptr_q];

  // storage has no reset; only the pointers, count and room/empty flags carry state
  always_ff @(posedge clock_in)
  begin
    if (push)
      mem_q[wr_ptr_q] <= in_data_in;
  end

  // pointers and room/empty flags kept as flops
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      room_q <= 1'b1;
      empty_q <= 1'b1;
    end
    else
    begin
      if (push)
        wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop)
        rd_ptr_q <= rd_ptr_q + 1'b1;
      if (push && !pop)
      begin
        count_q <= count_q + 1'b1;
        room_q <= (count_q != (AW+1)'(DEPTH - 1));
        empty_q <= 1'b0;
      end
      else if (pop && !push)
      begin
        count_q <= count_q - 1'b1;
        room_q <= 1'b1;
        empty_q <= (count_q == (AW+1)'(1));
      end
    end
  end
endmodule

// Notes on behaviour
// - any alignment; odd words take two cycles
// - address lines 23..1, two lane enables
// - byte enable low only for active lanes
// - each cycle at least two bus states
// - fixed pin levels while reset held
// - sixteen megabyte memory, 64k io space
// - coprocessor io at 8000f8..8000ff
// - 16-bit data, 23 lines plus enables
// - three definition signals valid with address
// - only the eight listed cycle kinds
// - idle: cycle ended, no new strobe
// - hold acknowledge high throughout hold
// - two-state cycles allowed at any address
// - ready ends cycle; otherwise second repeats
// - next-address input chooses pipelining per cycle
// - pipelined next address issued with strobe
// - fastest pipelined cycle is two states
// - first cycle after idle never pipelined
// - ready sampled at each second-state end
// - read data latched; write data held
module cbm_master #(
  parameter int DEPTH = cbm_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // request stream
  input wire logic req_valid_in,
  input wire cbm_pkg::cbm_req_t req_in,
  output logic req_ready_out,
  // read answers
  output logic rsp_valid_out,
  output logic [15:0] rsp_data_out,
  // bus status
  output logic bus_idle_out,
  // local bus
  cbm_bus_if.dev bus
);
  // ****************************************************************
  // request queue and cycle descriptor
  // ****************************************************************
  cbm_pkg::cbm_req_t head;
  cbm_pkg::cbm_cyc_t desc, cur_q, nxt_q;
  cbm_pkg::cbm_state_t st_q;
  logic head_valid, pop, part_q, last, is_rd, is_wr, split, io_kind;
  logic [23:0] eff, ea;
  logic ph_q, state_end, mid, na_seen_q, ack, issue, pipe_issue, hold_req;
  logic ads_n_q, hold_ack_q, dev_oe_q, rsp_valid_q, idle_q;
  logic [15:0] dev_data_q, rsp_q;
  logic [7:0] rbyte_q;

  cbm_req_fifo #(.WIDTH($bits(cbm_pkg::cbm_req_t)), .DEPTH(DEPTH)) u_fifo (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .in_valid_in(req_valid_in),
    .in_data_in(req_in),
    .in_ready_out(req_ready_out),
    .out_valid_out(head_valid),
    .out_data_out(head),
    .out_ready_in(pop)
  );

  // build the next bus cycle from the queue head and the split half
  always_comb
  begin
    desc = '0;
    io_kind = head.kind inside {cbm_pkg::CBM_IO_RD, cbm_pkg::CBM_IO_WR};
    eff = head.addr;
    if (io_kind && !(head.addr >= cbm_pkg::COPRO_FIRST && head.addr <= cbm_pkg::COPRO_LAST))
      eff = head.addr & cbm_pkg::IO_SPACE_TOP;
    is_rd = head.kind inside {cbm_pkg::CBM_MEM_RD, cbm_pkg::CBM_MEM_RD_LK, cbm_pkg::CBM_IO_RD,
                              cbm_pkg::CBM_INT_ACK};
    is_wr = head.kind inside {cbm_pkg::CBM_MEM_WR, cbm_pkg::CBM_MEM_WR_LK, cbm_pkg::CBM_IO_WR};
    split = head.word && eff[0] && (is_rd || is_wr) && head.kind != cbm_pkg::CBM_INT_ACK;
    ea = eff + {23'h000000, part_q};
    last = !split || part_q;
    case (head.kind)
      cbm_pkg::CBM_MEM_RD, cbm_pkg::CBM_MEM_RD_LK: desc.def = cbm_pkg::DEF_MEM_RD;
      cbm_pkg::CBM_MEM_WR, cbm_pkg::CBM_MEM_WR_LK: desc.def = cbm_pkg::DEF_MEM_WR;
      cbm_pkg::CBM_IO_RD: desc.def = cbm_pkg::DEF_IO_RD;
      cbm_pkg::CBM_IO_WR: desc.def = cbm_pkg::DEF_IO_WR;
      cbm_pkg::CBM_INT_ACK: desc.def = cbm_pkg::DEF_INT_ACK;
      default: desc.def = cbm_pkg::DEF_HALT;
    endcase
    desc.lock_n = !(head.kind inside {cbm_pkg::CBM_MEM_RD_LK, cbm_pkg::CBM_MEM_WR_LK,
                                      cbm_pkg::CBM_INT_ACK});
    desc.addr_hi = ea[23:1];
    desc.rd = is_rd;
    desc.wr = is_wr;
    desc.odd = ea[0];
    desc.split_lo = split && !part_q;
    desc.split_hi = split && part_q;
    // lane selection: odd byte rides the high lane
    if (!(is_rd || is_wr) || head.kind == cbm_pkg::CBM_INT_ACK)
      desc.ben_n = cbm_pkg::BEN_LOW_ONLY;
    else if (split && !part_q)
    begin
      desc.ben_n = cbm_pkg::BEN_HIGH_ONLY;
      desc.wdata = {head.wdata[7:0], 8'h00};
    end
    else if (split)
    begin
      desc.ben_n = cbm_pkg::BEN_LOW_ONLY;
      desc.wdata = {8'h00, head.wdata[15:8]};
    end
    else if (head.word)
    begin
      desc.ben_n = cbm_pkg::BEN_BOTH;
      desc.wdata = head.wdata;
    end
    else
    begin
      desc.ben_n = ea[0] ? cbm_pkg::BEN_HIGH_ONLY : cbm_pkg::BEN_LOW_ONLY;
      desc.wdata = {head.wdata[7:0], head.wdata[7:0]};
    end
  end

  // ****************************************************************
  // bus state timing
  // ****************************************************************
  assign state_end = ph_q; // second clock of a bus state
  assign mid = !ph_q;
  assign hold_req = bus.hold_req;
  assign ack = state_end && !bus.ready_n &&
               (st_q == cbm_pkg::CBM_ST_SECOND || st_q == cbm_pkg::CBM_ST_PIPE_SECOND);
  assign pipe_issue = state_end && head_valid && bus.ready_n && na_seen_q &&
                      st_q == cbm_pkg::CBM_ST_SECOND;
  assign issue = pipe_issue || (state_end && head_valid && !hold_req &&
                 (st_q == cbm_pkg::CBM_ST_IDLE || (ack && st_q == cbm_pkg::CBM_ST_SECOND)));
  assign pop = issue && last;

  // divider: one bus state is two input clocks
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
      ph_q <= 1'b0;
    else
      ph_q <= !ph_q;
  end

  // split progress follows each issued half
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
      part_q <= 1'b0;
    else if (issue)
      part_q <= !last;
  end

  // bus state machine
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      st_q <= cbm_pkg::CBM_ST_IDLE;
      hold_ack_q <= cbm_pkg::RST_HOLD_ACK;
    end
    else if (state_end)
    begin
      case (st_q)
        cbm_pkg::CBM_ST_IDLE:
          if (hold_req)
            st_q <= cbm_pkg::CBM_ST_HOLD;
          else if (issue)
            st_q <= cbm_pkg::CBM_ST_FIRST;
        cbm_pkg::CBM_ST_HOLD:
          if (!hold_req)
            st_q <= cbm_pkg::CBM_ST_IDLE;
        cbm_pkg::CBM_ST_FIRST:
          st_q <= cbm_pkg::CBM_ST_SECOND;
        cbm_pkg::CBM_ST_SECOND:
          if (ack)
          begin
            if (hold_req)
              st_q <= cbm_pkg::CBM_ST_HOLD;
            else if (issue)
              st_q <= cbm_pkg::CBM_ST_FIRST;
            else
              st_q <= cbm_pkg::CBM_ST_IDLE;
          end
          else if (pipe_issue)
            st_q <= cbm_pkg::CBM_ST_PIPE_SECOND;
        cbm_pkg::CBM_ST_PIPE_SECOND:
          if (ack)
            st_q <= cbm_pkg::CBM_ST_SECOND;
        default:
          st_q <= cbm_pkg::CBM_ST_IDLE;
      endcase
      hold_ack_q <= (st_q == cbm_pkg::CBM_ST_HOLD && hold_req) ||
                    (hold_req && (st_q == cbm_pkg::CBM_ST_IDLE ||
                                  (ack && st_q == cbm_pkg::CBM_ST_SECOND)));
    end
  end

  // next-address input is looked at only mid-way through a plain second state
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
      na_seen_q <= 1'b0;
    else if (issue || ack)
      na_seen_q <= 1'b0;
    else if (mid && st_q == cbm_pkg::CBM_ST_SECOND && !bus.next_addr_req_n)
      na_seen_q <= 1'b1;
  end

  // active and pipelined cycle descriptors
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      cur_q <= '0;
      nxt_q <= '0;
    end
    else if (pipe_issue)
      nxt_q <= desc;
    else if (issue)
      cur_q <= desc;
    else if (ack && st_q == cbm_pkg::CBM_ST_PIPE_SECOND)
      cur_q <= nxt_q;
  end

  // ****************************************************************
  // address, definition and strobe outputs
  // ****************************************************************
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      ads_n_q <= cbm_pkg::RST_ADS_N;
      bus.addr_hi <= cbm_pkg::RST_ADDR_HI;
      {bus.high_byte_en_n, bus.low_byte_en_n} <= cbm_pkg::RST_BEN_N;
      bus.mem_io <= cbm_pkg::RST_MEM_IO;
      bus.data_ctl <= cbm_pkg::RST_DATA_CTL;
      bus.wr_rd <= cbm_pkg::RST_WR_RD;
      bus.lock_n <= cbm_pkg::RST_LOCK_N;
    end
    else if (state_end)
    begin
      ads_n_q <= !issue;
      if (issue)
      begin
        bus.addr_hi <= desc.addr_hi;
        {bus.high_byte_en_n, bus.low_byte_en_n} <= desc.ben_n;
        {bus.mem_io, bus.data_ctl, bus.wr_rd} <= desc.def;
        bus.lock_n <= desc.lock_n;
      end
    end
  end
  assign bus.addr_strobe_n = ads_n_q;
  assign bus.hold_ack = hold_ack_q;

  // idle once the last cycle ended and no strobe followed it
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
      idle_q <= 1'b1;
    else if (state_end)
      idle_q <= !issue && (st_q == cbm_pkg::CBM_ST_IDLE || (ack && st_q == cbm_pkg::CBM_ST_SECOND) ||
                           st_q == cbm_pkg::CBM_ST_HOLD);
  end
  assign bus_idle_out = idle_q;

  // ****************************************************************
  // data lines
  // ****************************************************************
  // write data from the second half of the first state, or of the second state for a pipelined cycle; old data kept through
  // the first half of the state after the ack, since a new value only loads mid-state
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      dev_oe_q <= 1'b0;
      dev_data_q <= '0;
    end
    else if (mid)
    begin
      dev_oe_q <= cur_q.wr && st_q inside {cbm_pkg::CBM_ST_FIRST, cbm_pkg::CBM_ST_SECOND,
                                           cbm_pkg::CBM_ST_PIPE_SECOND};
      if (cur_q.wr && st_q != cbm_pkg::CBM_ST_IDLE && st_q != cbm_pkg::CBM_ST_HOLD)
        dev_data_q <= cur_q.wdata;
    end
  end
  assign bus.dev_data = dev_data_q;
  assign bus.dev_data_oe = dev_oe_q;

  // read data latched on the ack edge; split halves assembled low byte first
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      rsp_valid_q <= 1'b0;
      rsp_q <= '0;
      rbyte_q <= '0;
    end
    else
    begin
      rsp_valid_q <= ack && cur_q.rd && !cur_q.split_lo;
      if (ack && cur_q.rd)
      begin
        if (cur_q.split_lo)
          rbyte_q <= bus.data_bus[15:8];
        else if (cur_q.split_hi)
          rsp_q <= {bus.data_bus[7:0], rbyte_q};
        else if (cur_q.ben_n == cbm_pkg::BEN_BOTH)
          rsp_q <= bus.data_bus;
        else
          rsp_q <= {8'h00, cur_q.odd ? bus.data_bus[15:8] : bus.data_bus[7:0]};
      end
    end
  end
  assign rsp_valid_out = rsp_valid_q;
  assign rsp_data_out = rsp_q;
endmodule
`default_nettype wire

// >>> logic/cbm_system.sv
// system-side memory and io decode answering the cycle master
`timescale 1ns/1ps
`default_nettype none
module cbm_system #(
  parameter int RAM_WORDS = 256
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // configuration
  input wire logic [3:0] wait_states_in,
  input wire logic pipeline_en_in,
  input wire logic hold_req_in,
  input wire logic [7:0] int_vector_in,
  // observed events
  output logic io_wr_valid_out,
  output logic [15:0] io_wr_addr_out,
  output logic [15:0] io_wr_data_out,
  output logic halt_seen_out,
  // local bus
  cbm_bus_if.sys bus
);
  localparam int IW = $clog2(RAM_WORDS);
  if (RAM_WORDS < 2 || (1 << IW) != RAM_WORDS) $error("ram size must be a power of two");

  // ****************************************************************
  // cycle tracking
  // ****************************************************************
  logic [15:0] ram_q [RAM_WORDS];
  logic ph_q, active_q, second_q, pend_q, ready_n_q, na_n_q, hold_q, oe_q, done;
  logic [3:0] wcnt_q;
  logic [2:0] def_q, pdef_q;
  logic [22:0] addr_q, paddr_q;
  logic [1:0] ben_q, pben_q;
  logic [15:0] rdata_q;
  logic [IW-1:0] idx;

  assign idx = addr_q[IW-1:0];
  assign done = ph_q && active_q && second_q && !ready_n_q;

  // phase runs in step with the master; both leave reset together
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
      ph_q <= 1'b0;
    else
      ph_q <= !ph_q;
  end

  // a strobe seen mid-state opens a cycle or queues a pipelined one
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      active_q <= 1'b0;
      second_q <= 1'b0;
      pend_q <= 1'b0;
      wcnt_q <= '0;
      def_q <= '0;
      pdef_q <= '0;
      addr_q <= '0;
      paddr_q <= '0;
      ben_q <= '0;
      pben_q <= '0;
    end
    else if (!ph_q && !bus.addr_strobe_n)
    begin
      if (active_q)
      begin
        pend_q <= 1'b1;
        pdef_q <= {bus.mem_io, bus.data_ctl, bus.wr_rd};
        paddr_q <= bus.addr_hi;
        pben_q <= {bus.high_byte_en_n, bus.low_byte_en_n};
      end
      else
      begin
        active_q <= 1'b1;
        second_q <= 1'b0;
        wcnt_q <= wait_states_in;
        def_q <= {bus.mem_io, bus.data_ctl, bus.wr_rd};
        addr_q <= bus.addr_hi;
        ben_q <= {bus.high_byte_en_n, bus.low_byte_en_n};
      end
    end
    else if (ph_q && active_q)
    begin
      if (!second_q)
        second_q <= 1'b1;
      else if (done)
      begin
        // a queued address already had its first state
        active_q <= pend_q;
        pend_q <= 1'b0;
        wcnt_q <= wait_states_in;
        def_q <= pdef_q;
        addr_q <= paddr_q;
        ben_q <= pben_q;
      end
      else if (wcnt_q != 4'h0)
        wcnt_q <= wcnt_q - 4'h1;
    end
  end

  // ready low for the second half of the last second state
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      ready_n_q <= 1'b1;
      oe_q <= 1'b0;
      rdata_q <= '0;
    end
    else if (!ph_q)
    begin
      ready_n_q <= !(active_q && second_q && wcnt_q == 4'h0);
      oe_q <= active_q && second_q && wcnt_q == 4'h0 && !def_q[0];
      if (def_q == cbm_pkg::DEF_INT_ACK)
        rdata_q <= {8'h00, int_vector_in};
      else if (def_q == cbm_pkg::DEF_MEM_RD)
        rdata_q <= ram_q[idx];
      else
        rdata_q <= '0;
    end
    else
    begin
      ready_n_q <= 1'b1;
      oe_q <= 1'b0;
    end
  end

  // next-address request and hold request come from configuration
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      na_n_q <= 1'b1;
      hold_q <= 1'b0;
    end
    else
    begin
      na_n_q <= !pipeline_en_in;
      hold_q <= hold_req_in;
    end
  end

  // memory writes take only the enabled lanes
  always_ff @(posedge clock_in)
  begin
    if (done && def_q == cbm_pkg::DEF_MEM_WR)
    begin
      if (!ben_q[0])
        ram_q[idx][7:0] <= bus.data_bus[7:0];
      if (!ben_q[1])
        ram_q[idx][15:8] <= bus.data_bus[15:8];
    end
  end

  // io write and halt events reported one cycle after the ack
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      io_wr_valid_out <= 1'b0;
      io_wr_addr_out <= '0;
      io_wr_data_out <= '0;
      halt_seen_out <= 1'b0;
    end
    else
    begin
      io_wr_valid_out <= done && def_q == cbm_pkg::DEF_IO_WR;
      halt_seen_out <= done && def_q == cbm_pkg::DEF_HALT;
      if (done && def_q == cbm_pkg::DEF_IO_WR)
      begin
        io_wr_addr_out <= {addr_q[14:0], ben_q == cbm_pkg::BEN_HIGH_ONLY};
        io_wr_data_out <= bus.data_bus;
      end
    end
  end

  assign bus.ready_n = ready_n_q;
  assign bus.next_addr_req_n = na_n_q;
  assign bus.hold_req = hold_q;
  assign bus.sys_data = rdata_q;
  assign bus.sys_data_oe = oe_q;
endmodule
`default_nettype wire

// >>> test/cbm_checker.sv
// bus checker for the cycle master and system ends
`timescale 1ns/1ps
`default_nettype none
module cbm_checker (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // local bus
  input wire logic [22:0] addr_hi,
  input wire logic high_byte_en_n,
  input wire logic low_byte_en_n,
  input wire logic mem_io,
  input wire logic wr_rd,
  input wire logic data_ctl,
  input wire logic lock_n,
  input wire logic addr_strobe_n,
  input wire logic hold_ack,
  input wire logic dev_data_oe
);
  // ****************
  // phase tracking
  // ****************
  logic ph_q;
  wire logic [27:0] def_w = {addr_hi, high_byte_en_n, low_byte_en_n, mem_io, wr_rd, data_ctl};
  wire logic strb_w = !addr_strobe_n;
  wire logic ctl_w = strb_w && !data_ctl;
  // phase zero in the first clock after reset, as both ends count it
  always_ff @(posedge clock_in) ph_q <= reset_in ? 1'b0 : ~ph_q;
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);
  a_reset_levels: assert property ($fell(reset_in) |-> addr_strobe_n && !high_byte_en_n && !low_byte_en_n
    && &addr_hi && !wr_rd && data_ctl && !mem_io && lock_n && !hold_ack && !dev_data_oe) else $error("reset pins");
  a_strobe_width: assert property ($fell(addr_strobe_n) |=> strb_w ##1 !strb_w) else $error("strobe width");
  a_strobe_phase: assert property ($fell(addr_strobe_n) |-> !ph_q) else $error("strobe phase");
  a_addr_hold: assert property ($fell(addr_strobe_n) |=> $stable(def_w)[*3]) else $error("address moved");
  a_lane_used: assert property (strb_w |-> !(high_byte_en_n && low_byte_en_n)) else $error("no lane");
  a_io_range: assert property (strb_w && !mem_io && data_ctl |-> addr_hi[22:15] == 8'h00
    || {addr_hi[22:2], 3'h0} == 24'h8000f8) else $error("io address");
  a_write_drive: assert property ($fell(addr_strobe_n) && wr_rd && data_ctl |=> dev_data_oe[*4])
    else $error("write data dropped");
  a_ctl_lane: assert property (ctl_w |-> !low_byte_en_n && high_byte_en_n) else $error("control lane");
  a_ack_lock: assert property (ctl_w && !mem_io && !wr_rd |-> !lock_n) else $error("ack unlocked");
  a_hold_quiet: assert property (hold_ack |-> addr_strobe_n) else $error("strobe in hold");
endmodule
`default_nettype wire

// >>> test/tb.sv
// bench joining both ends of the local bus
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock_in, reset_in, req_valid_in, req_ready_out, rsp_valid_out, bus_idle_out;
  logic pipeline_en_in, hold_req_in, io_wr_valid_out, halt_seen_out;
  logic [3:0] wait_states_in;
  logic [15:0] rsp_data_out, io_wr_addr_out, io_wr_data_out;
  logic [31:0] io_q;
  cbm_pkg::cbm_req_t req_in;
  int error_cnt, n_checks, cyc, halts, i, n;
  cbm_bus_if bus ();
  cbm_master i_cbm_master (.clock_in, .reset_in, .req_valid_in, .req_in, .req_ready_out, .rsp_valid_out,
    .rsp_data_out, .bus_idle_out, .bus(bus));
  cbm_system i_cbm_system (.clock_in, .reset_in, .wait_states_in, .pipeline_en_in, .hold_req_in,
    .int_vector_in(8'ha5), .io_wr_valid_out, .io_wr_addr_out, .io_wr_data_out, .halt_seen_out, .bus(bus));
  cbm_checker i_cbm_checker (.clock_in, .reset_in, .addr_hi(bus.addr_hi), .high_byte_en_n(bus.high_byte_en_n),
    .low_byte_en_n(bus.low_byte_en_n), .mem_io(bus.mem_io), .wr_rd(bus.wr_rd), .data_ctl(bus.data_ctl),
    .lock_n(bus.lock_n), .addr_strobe_n(bus.addr_strobe_n), .hold_ack(bus.hold_ack), .dev_data_oe(bus.dev_data_oe));
  // free running clock
  initial
  begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end
  // ****************
  // access tasks
  // ****************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // request held until the fifo takes it
  task put(input cbm_pkg::cbm_kind_t k, input logic w, input logic [23:0] a, input logic [15:0] d);
    @(negedge clock_in);
    req_valid_in = 1'b1;
    req_in = '{k, w, a, d};
    while (req_ready_out !== 1'b1) @(negedge clock_in);
    @(negedge clock_in);
    req_valid_in = 1'b0;
  endtask
  // one read, answer waited for under a bound
  task rd(input cbm_pkg::cbm_kind_t k, input logic w, input logic [23:0] a, input logic [15:0] e);
    int j;
    put(k, w, a, 16'h0000);
    for (j = 0; j < 300 && rsp_valid_out !== 1'b1; j++) @(negedge clock_in);
    chk(rsp_valid_out, 1);
    chk(rsp_data_out, e);
    @(negedge clock_in);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // pulses caught mid-cycle; a hang ends the run
  always @(negedge clock_in)
  begin
    cyc++;
    if (io_wr_valid_out === 1'b1) io_q = {io_wr_addr_out, io_wr_data_out};
    if (halt_seen_out === 1'b1) halts++;
    if (cyc == 20000)
    begin
      error_cnt++;
      print_verdict;
    end
  end
  // ****************
  // tests
  // ****************
  initial
  begin
    {reset_in, req_valid_in, req_in, pipeline_en_in, hold_req_in, wait_states_in, io_q} = '0;
    reset_in = 1'b1;
    repeat (5) @(negedge clock_in);
    reset_in = 1'b0;
    chk(bus_idle_out, 1);
    $display("reset done");
    // lanes, byte reads land low
    put(cbm_pkg::CBM_MEM_WR, 1, 24'h000020, 16'hbeef);
    put(cbm_pkg::CBM_MEM_WR, 0, 24'h000021, 16'h5a5a);
    rd(cbm_pkg::CBM_MEM_RD, 1, 24'h000020, 16'h5aef);
    rd(cbm_pkg::CBM_MEM_RD, 0, 24'h000021, 16'h005a);
    // odd word split over two cycles
    put(cbm_pkg::CBM_MEM_WR, 1, 24'h000030, 16'h0000);
    put(cbm_pkg::CBM_MEM_WR, 1, 24'h000032, 16'h0000);
    put(cbm_pkg::CBM_MEM_WR_LK, 1, 24'h000031, 16'h1234);
    rd(cbm_pkg::CBM_MEM_RD_LK, 1, 24'h000031, 16'h1234);
    rd(cbm_pkg::CBM_MEM_RD, 1, 24'h000030, 16'h3400);
    rd(cbm_pkg::CBM_MEM_RD, 1, 24'h000032, 16'h0012);
    $display("alignment done");
    // coprocessor, io, acknowledge and halt
    put(cbm_pkg::CBM_IO_WR, 1, 24'h8000fa, 16'h0001);
    put(cbm_pkg::CBM_IO_WR, 1, 24'h001234, 16'habcd);
    rd(cbm_pkg::CBM_INT_ACK, 0, 24'h000000, 16'h00a5);
    chk(io_q, 32'h1234abcd);
    put(cbm_pkg::CBM_HALT, 0, 24'h000000, 16'h0000);
    rd(cbm_pkg::CBM_IO_RD, 1, 24'h000100, 16'h0000);
    chk(halts, 1);
    $display("cycle kinds done");
    // bus frozen in hold while the fifo fills, then drains pipelined with waits
    wait_states_in = 4'h2;
    pipeline_en_in = 1'b1;
    hold_req_in = 1'b1;
    repeat (20) @(negedge clock_in);
    chk(bus.hold_ack, 1);
    for (n = 0; n < 12 && req_ready_out === 1'b1; n++) put(cbm_pkg::CBM_MEM_WR, 1, 24'(64 + 2 * n), 16'(n));
    chk(n >= 8 && req_ready_out === 1'b0, 1);
    hold_req_in = 1'b0;
    for (i = 0; i < n; i++) rd(cbm_pkg::CBM_MEM_RD, 1, 24'(64 + 2 * i), 16'(i));
    repeat (20) @(negedge clock_in);
    chk(bus_idle_out, 1);
    $display("hold and pipeline done");
    print_verdict;
  end
endmodule
`default_nettype wire
